//--- smc_defines.vh
// constants for the serial mode control block
`ifndef SMC_DEFINES_VH
`define SMC_DEFINES_VH
`define SMC_ADDR_W        4
`define SMC_MODE_ADDR     4'h0
`define SMC_STAT_ADDR     4'h1
`define SMC_BAUD_ADDR     4'h2
`define SMC_MODE_RESET    16'h0000
`define SMC_BAUD_RESET    16'h0000
`define SMC_MODE_WMASK    16'hBBFF
`define SMC_BIT_ENABLE    15
`define SMC_BIT_IDLE_STOP 13
`define SMC_BIT_IRDEC     12
`define SMC_BIT_RQMODE    11
`define SMC_BIT_PEN_HI    9
`define SMC_BIT_PEN_LO    8
`define SMC_BIT_WAKE      7
`define SMC_BIT_LOOP      6
`define SMC_BIT_AUTORATE  5
`define SMC_BIT_RXINV     4
`define SMC_BIT_HSPEED    3
`define SMC_PEN_TXRX      2'h0
`define SMC_PEN_RTS       2'h1
`define SMC_PEN_ALL       2'h2
`define SMC_CLK_STD       5'h10
`define SMC_CLK_HS        5'h04
`define SMC_IR_PULSE      5'h03
`endif

//--- smc_rate_gen.v
// baud tick generator and per-bit clock divider
`timescale 1ns/100ps
module smc_rate_gen (
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  input  wire        ce_i,
  input  wire [15:0] divisor_i,
  input  wire        high_speed_i,
  output reg         baud_tick_o,
  output reg         bit_tick_o,
  output reg  [4:0]  phase_o
);
`include "smc_defines.vh"
  reg  [15:0] div_cnt;
  wire [4:0]  per_bit = high_speed_i ? `SMC_CLK_HS : `SMC_CLK_STD;
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      div_cnt     <= 16'h0000;
      baud_tick_o <= 1'b0;
      bit_tick_o  <= 1'b0;
      phase_o     <= 5'h00;
    end else if (ce_i) begin
      baud_tick_o <= 1'b0;
      bit_tick_o  <= 1'b0;
      if (div_cnt >= divisor_i) begin
        div_cnt     <= 16'h0000;
        baud_tick_o <= 1'b1;
        // 16 ticks per bit standard, 4 in high speed
        if (phase_o + 5'h01 >= per_bit) begin
          phase_o    <= 5'h00;
          bit_tick_o <= 1'b1;
        end else begin
          phase_o <= phase_o + 5'h01;
        end
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end
endmodule // smc_rate_gen

//--- smc_mode_ctrl.v
// serial mode control register, pin ownership, infrared codec, loopback, wake
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/100ps
//Contract
// - one bit enables infrared pulse encoder on transmit and decoder on receive
// - infrared coding works only in sixteen-clocks-per-bit mode
// - sixteen baud clocks per bit normally, four with high speed set
// - bit 11 selects simplex or flow-control behaviour of request pin
// - pin field 01 takes tx rx rts; 10 also takes cts
// - pin field 00 takes only tx and rx; others stay port-latch
// - wake bit samples receive pin in sleep, pulses event on falling edge
// - wake bit clears itself on next rising edge after wake
module smc_mode_ctrl (
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  input  wire        ce_i,
  input  wire [3:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  input  wire        sleep_i,
  input  wire        tx_data_i,
  input  wire        rts_req_i,
  input  wire        tx_busy_i,
  input  wire        serial_in_pin_i,
  input  wire        flow_grant_in_pin_i,
  input  wire        port_rts_i,
  output reg         serial_out_pin_o,
  output reg         serial_out_pin_oe_o,
  output reg         flow_request_out_pin_o,
  output reg         flow_request_out_pin_oe_o,
  output reg         flow_grant_owned_o,
  output reg         rx_data_o,
  output reg         cts_o,
  output reg         wake_event_o,
  output reg         baud_tick_o,
  output reg         bit_tick_o
);
`include "smc_defines.vh"
  reg  [15:0] serial_mode_control;
  reg  [15:0] baud_divisor;
  reg         rx_meta;
  reg         rx_sync;
  reg         rx_prev;
  reg         cts_meta;
  reg         cts_sync;
  reg         woke;
  reg  [4:0]  ir_cnt;
  reg         ir_tx_prev;
  reg         ir_rx_hold;
  reg  [15:0] next_mode;
  reg  [15:0] next_rdata;
  wire        gen_baud;
  wire        gen_bit;

  wire enable     = serial_mode_control[`SMC_BIT_ENABLE];
  wire ir_on      = serial_mode_control[`SMC_BIT_IRDEC] &
                    ~serial_mode_control[`SMC_BIT_HSPEED];
  wire [1:0] pen  = serial_mode_control[`SMC_BIT_PEN_HI:`SMC_BIT_PEN_LO];
  wire loop_on    = serial_mode_control[`SMC_BIT_LOOP];
  wire rx_level   = rx_sync ^ serial_mode_control[`SMC_BIT_RXINV];
  wire fall_edge  = rx_prev & ~rx_level;
  wire rise_edge  = ~rx_prev & rx_level;
  wire own_rts    = enable & ((pen == `SMC_PEN_RTS) | (pen == `SMC_PEN_ALL));
  wire own_cts    = enable & (pen == `SMC_PEN_ALL);
  // simplex: rts marks transmitter busy; flow control: rts asks peer to send
  wire rts_level  = serial_mode_control[`SMC_BIT_RQMODE] ? ~tx_busy_i : ~rts_req_i;
  // infrared: a zero bit becomes a short high pulse at bit start
  wire ir_tx      = (~tx_data_i) & (ir_cnt < `SMC_IR_PULSE);
  wire tx_line    = ir_on ? ir_tx : tx_data_i;
  wire rx_raw     = loop_on ? tx_data_i : rx_level;
  wire rx_line    = ir_on ? ~ir_rx_hold : rx_raw;

  smc_rate_gen u_rate (
    .mclk_i       (mclk_i),
    .sys_rst_i    (sys_rst_i),
    .ce_i         (ce_i),
    .divisor_i    (baud_divisor),
    .high_speed_i (serial_mode_control[`SMC_BIT_HSPEED]),
    .baud_tick_o  (gen_baud),
    .bit_tick_o   (gen_bit),
    .phase_o      ()
  );

  always @* begin
    next_mode = serial_mode_control;
    if (wr_i && addr_i == `SMC_MODE_ADDR)
      next_mode = wdata_i & `SMC_MODE_WMASK;
    // hardware clear after wake; takes priority over a write in the same cycle
    if (woke && rise_edge)
      next_mode[`SMC_BIT_WAKE] = 1'b0;
  end

  // read data fall back to zero so a stale word is never seen
  always @* begin
    next_rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        `SMC_MODE_ADDR: next_rdata = serial_mode_control;
        `SMC_BAUD_ADDR: next_rdata = baud_divisor;
        `SMC_STAT_ADDR: next_rdata = {11'h000, woke, own_cts, own_rts, ir_on, rx_level};
        default:        next_rdata = 16'h0000;
      endcase
    end
  end

  // both pins are asynchronous: two flops before any logic reads them
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rx_meta  <= 1'b1;
      rx_sync  <= 1'b1;
      cts_meta <= 1'b1;
      cts_sync <= 1'b1;
    end else if (ce_i) begin
      rx_meta  <= serial_in_pin_i;
      rx_sync  <= rx_meta;
      cts_meta <= flow_grant_in_pin_i;
      cts_sync <= cts_meta;
    end
  end

  // edge history starts at the idle level so reset brings no false start bit
  always @(posedge mclk_i) begin
    if (sys_rst_i)
      rx_prev <= 1'b1;
    else if (ce_i)
      rx_prev <= rx_level;
  end

  // a write lands in the cycle after its strobe
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      serial_mode_control <= `SMC_MODE_RESET;
    end else if (ce_i) begin
      serial_mode_control <= next_mode;
    end
  end

  always @(posedge mclk_i) begin
    if (sys_rst_i)
      rdata_o <= 16'h0000;
    else if (ce_i)
      rdata_o <= next_rdata;
  end

  // a divisor of zero gives one baud tick per system clock
  always @(posedge mclk_i) begin
    if (sys_rst_i)
      baud_divisor <= `SMC_BAUD_RESET;
    else if (ce_i && wr_i && addr_i == `SMC_BAUD_ADDR)
      baud_divisor <= wdata_i;
  end

  // wake: falling edge during sleep raises one event and arms the auto-clear
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      woke         <= 1'b0;
      wake_event_o <= 1'b0;
    end else if (ce_i) begin
      wake_event_o <= 1'b0;
      if (serial_mode_control[`SMC_BIT_WAKE] && sleep_i && fall_edge && !woke) begin
        wake_event_o <= 1'b1;
        woke         <= 1'b1;
      end else if (woke && rise_edge) begin
        woke <= 1'b0;
      end
    end
  end

  // infrared pulse timing restarts at each transmit bit edge
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ir_cnt     <= 5'h00;
      ir_tx_prev <= 1'b1;
    end else if (ce_i) begin
      ir_tx_prev <= tx_data_i;
      if (gen_bit || ir_tx_prev != tx_data_i)
        ir_cnt <= 5'h00;
      else if (gen_baud && ir_cnt != 5'h1F)
        ir_cnt <= ir_cnt + 5'h01;
    end
  end

  // decoder stretches a received pulse across one bit time
  always @(posedge mclk_i) begin
    if (sys_rst_i)
      ir_rx_hold <= 1'b0;
    else if (ce_i && ir_on && rx_raw)
      ir_rx_hold <= 1'b1;
    else if (ce_i && gen_bit)
      ir_rx_hold <= 1'b0;
  end

  // transmit and receive lines
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      serial_out_pin_o    <= 1'b1;
      serial_out_pin_oe_o <= 1'b0;
      rx_data_o           <= 1'b1;
    end else if (ce_i) begin
      serial_out_pin_o    <= tx_line;
      serial_out_pin_oe_o <= enable;
      rx_data_o           <= rx_line;
    end
  end

  // flow-control pins fall back to the port latch when not owned
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      flow_request_out_pin_o    <= 1'b1;
      flow_request_out_pin_oe_o <= 1'b0;
      flow_grant_owned_o        <= 1'b0;
      cts_o                     <= 1'b0;
    end else if (ce_i) begin
      flow_request_out_pin_o    <= own_rts ? rts_level : port_rts_i;
      flow_request_out_pin_oe_o <= own_rts;
      flow_grant_owned_o        <= own_cts;
      cts_o                     <= own_cts ? ~cts_sync : 1'b1;
    end
  end

  // tick strobes re-timed so every output comes straight from a flop
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      baud_tick_o <= 1'b0;
      bit_tick_o  <= 1'b0;
    end else if (ce_i) begin
      baud_tick_o <= gen_baud;
      bit_tick_o  <= gen_bit;
    end
  end
endmodule // smc_mode_ctrl

//--- smc_mode_monitor.sv
// checker for the serial mode control ports
`timescale 1ns/100ps
module smc_mode_monitor (
  input wire        mclk_i,
  input wire        sys_rst_i,
  input wire [3:0]  addr_i,
  input wire [15:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire        sleep_i,
  input wire [15:0] rdata_o,
  input wire        serial_out_pin_oe_o,
  input wire        flow_request_out_pin_oe_o,
  input wire        flow_grant_owned_o,
  input wire        wake_event_o,
  input wire        baud_tick_o,
  input wire        bit_tick_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic [4:0] bcnt;
  wire        mw = wr_i && addr_i == 4'h0;
  // baud ticks seen since the last bit tick
  always @(posedge mclk_i) begin
    bcnt <= (sys_rst_i || bit_tick_o) ? 5'h00 : bcnt + 5'(baud_tick_o);
  end
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000) else $error("stale read data");
  a_resv_zero: assert property (rd_i && addr_i == 4'h0 |=>
    !rdata_o[14] && !rdata_o[10]) else $error("reserved bit set");
  a_tx_owned: assert property (mw |-> ##2
    serial_out_pin_oe_o == $past(wdata_i[15], 2)) else $error("tx pin ownership");
  a_rts_owned: assert property (mw |-> ##2 flow_request_out_pin_oe_o ==
    ($past(wdata_i[15], 2) && ($past(wdata_i[9:8], 2) inside {2'h1, 2'h2})))
    else $error("request pin ownership");
  a_grant_owned: assert property (mw |-> ##2 flow_grant_owned_o ==
    ($past(wdata_i[15], 2) && $past(wdata_i[9:8], 2) == 2'h2)) else $error("grant ownership");
  a_wake_pulse: assert property (wake_event_o |=> !wake_event_o) else $error("wake too long");
  a_wake_asleep: assert property (!sleep_i [*4] |=> !wake_event_o) else $error("wake awake");
  a_bit_bound: assert property (bcnt <= 5'd16) else $error("bit tick late");
  cover property (wake_event_o);
  cover property (bit_tick_o);
  cover property (flow_grant_owned_o);
endmodule // smc_mode_monitor
bind smc_mode_ctrl smc_mode_monitor smc_mode_monitor_inst (.*);

//--- smc_far_end.sv
// far-end serial device: start-bit sender and active-low grant line
`timescale 1ns/100ps
module smc_far_end #(parameter int BIT = 16) (
  input  wire  mclk_i,
  input  wire  go_i,
  input  wire  grant_i,
  output logic line_o,
  output logic grant_n_o
);
  int cnt = 0;
  initial begin
    line_o = 1'b1;
    grant_n_o = 1'b1;
  end
  // idle line high; a start bit stays low one bit time, then the line rises
  always @(posedge mclk_i) begin
    grant_n_o <= !grant_i;
    cnt <= go_i ? BIT : (cnt > 0 ? cnt - 1 : 0);
    line_o <= !(go_i || cnt > 1);
  end
endmodule // smc_far_end

//--- smc_mode_ctrl_tb.sv
// testbench for the serial mode control block
`timescale 1ns/100ps
`include "smc_defines.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR %0t got %h want %h", $time, a, e); end end
module smc_mode_ctrl_tb;
  logic mclk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, sleep_i = 0, tx_data_i = 1;
  logic rts_req_i = 1, tx_busy_i = 0, go = 0, grant = 0;
  logic [3:0] addr_i = 0;
  logic [15:0] wdata_i = 0, rdata_o, q;
  wire so, soe, ro, roe, gown, rxd, cts, wk, bt, kt, line, grant_n;
  int n_fail = 0, checks_done = 0, cyc = 0, k;
  smc_mode_ctrl smc_mode_ctrl_inst (.mclk_i, .sys_rst_i, .ce_i(1'b1), .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .sleep_i, .tx_data_i, .rts_req_i, .tx_busy_i,
    .serial_in_pin_i(line), .flow_grant_in_pin_i(grant_n), .port_rts_i(1'b1),
    .serial_out_pin_o(so), .serial_out_pin_oe_o(soe), .flow_request_out_pin_o(ro),
    .flow_request_out_pin_oe_o(roe), .flow_grant_owned_o(gown), .rx_data_o(rxd),
    .cts_o(cts), .wake_event_o(wk), .baud_tick_o(bt), .bit_tick_o(kt));
  smc_far_end smc_far_end_inst (.mclk_i, .go_i(go), .grant_i(grant), .line_o(line),
    .grant_n_o(grant_n));
  initial forever #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (++cyc == 3000) begin n_fail++; give_verdict; end
  task automatic wr(input [3:0] a, input [15:0] d);
    @(posedge mclk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge mclk_i);
    wr_i <= 0;
  endtask
  task automatic rd(input [3:0] a);
    @(posedge mclk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge mclk_i);
    rd_i <= 0;
    #1 q = rdata_o;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // counts wake pulses while a start bit crosses the line
  task automatic wake_run;
    @(posedge mclk_i);
    go <= 1;
    @(posedge mclk_i);
    go <= 0;
    k = 0;
    repeat (40) begin @(posedge mclk_i); #1 k += wk; end
  endtask
  task automatic tick_gap(output int n);
    n = 0;
    do begin @(posedge mclk_i); #1 n++; end while (kt !== 1'b1 && n < 40);
  endtask
  task give_verdict;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 0;
    rd(`SMC_MODE_ADDR); `CHK(q, `SMC_MODE_RESET)
    wr(`SMC_MODE_ADDR, 16'hFFF8);
    rd(`SMC_MODE_ADDR); `CHK(q, 16'hBBF8)
    rd(4'h7); `CHK(q, 16'h0000)
    $display("register test done");
    for (int f = 0; f < 3; f++) begin
      wr(`SMC_MODE_ADDR, 16'h8000 | 16'(f << 8));
      settle(1); `CHK({soe, roe, gown, ro}, {1'b1, f != 0, f == 2, f == 0})
    end
    wr(`SMC_MODE_ADDR, 16'h8100);
    settle(1); `CHK(ro, 1'b0)
    wr(`SMC_MODE_ADDR, 16'h8900);
    settle(1); `CHK(ro, 1'b1)
    wr(`SMC_MODE_ADDR, 16'h8200);
    settle(6); `CHK(cts, 1'b0)
    @(posedge mclk_i) grant <= 1;
    settle(6); `CHK(cts, 1'b1)
    @(posedge mclk_i) tx_data_i <= 0;
    wr(`SMC_MODE_ADDR, 16'h8040);
    settle(6); `CHK(rxd, 1'b0)
    wr(`SMC_MODE_ADDR, 16'h8000);
    settle(6); `CHK(rxd, 1'b1)
    $display("pin test done");
    @(posedge mclk_i) sleep_i <= 1;
    wr(`SMC_MODE_ADDR, 16'h8080);
    wake_run; `CHK(k, 1)
    rd(`SMC_MODE_ADDR); `CHK(q, 16'h8000)
    @(posedge mclk_i) sleep_i <= 0;
    wr(`SMC_MODE_ADDR, 16'h8080);
    wake_run; `CHK(k, 0)
    $display("wake test done");
    wr(`SMC_MODE_ADDR, 16'h9000);
    rd(`SMC_STAT_ADDR); `CHK(q[1], 1'b1)
    // a steady zero bit sends one short pulse per sixteen baud ticks
    k = 0;
    repeat (16) begin @(posedge mclk_i); #1 k += so; end
    `CHK(k, `SMC_IR_PULSE)
    wr(`SMC_MODE_ADDR, 16'h9008);
    rd(`SMC_STAT_ADDR); `CHK(q[1], 1'b0)
    `CHK(so, 1'b0)
    // divisor 1: one baud tick every two clocks
    wr(`SMC_BAUD_ADDR, 16'h0001);
    rd(`SMC_BAUD_ADDR); `CHK(q, 16'h0001)
    for (int h = 0; h < 2; h++) begin
      wr(`SMC_MODE_ADDR, h ? 16'h8008 : 16'h8000);
      settle(20);
      tick_gap(k);
      tick_gap(k); `CHK(k, (h ? 4 : 16) * 2)
    end
    $display("rate test done");
    give_verdict;
  end
endmodule // smc_mode_ctrl_tb
